//--- rtl/abbps_sequencer.sv
// Power-on and power-off sequencer with interrupt combiner and AHB-Lite registers
// Contract
// - Valid battery plug creates internal reset; sequencer then starts from off and makes one power-on attempt by itself.
// - Power-on enables reference first, then checks main battery above 3.2V.
// - After check, enable core, analog, memory, RAM regulators; wait regulator good.
// - Set on flag, release analog reset, raise system reset, then enable oscillator.
// - Power-off starts when both batteries lack voltage or both are removed.
// - Power-off asserts warning interrupt, then waits five slow clock periods.
// - Clear on flag, assert analog reset, disable masked regulators and reference, clear low flag.
// - Power button press and abnormal voltage each raise an interrupt.
// - Button and charger detection keep running while switched off.
// - Monitoring ADC, charger and power control interrupts combine into one host interrupt.
module abbps_sequencer
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        mainBatteryPresent,
    input  wire logic        backupBatteryPresent,
    input  wire logic        mainBatteryAbove3v2,
    input  wire logic        backupBatteryOk,
    input  wire logic        regulatorGood,
    input  wire logic        power_button,
    input  wire logic        chargerPresent,
    input  wire logic        abnormalVoltage,
    input  wire logic        monitoring_adc_irq,
    input  wire logic        charger_interface_irq,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             referenceEnable,
    output logic             core_regulator_en,
    output logic             analog_regulator_en,
    output logic             memory_regulator_en,
    output logic             ram_regulator_en,
    output logic             on_state_flag,
    output logic             analog_reset_n,
    output logic             system_reset_out_n,
    output logic             oscillatorEnable,
    output logic             main_battery_low_flag,
    output logic             power_off_warning_irq,
    output logic             host_combined_irq
);
    import abbps_pkg::*;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;
    wire  [NSYNC-1:0] rawIn = {mainBatteryPresent, backupBatteryPresent, mainBatteryAbove3v2, backupBatteryOk,
                               regulatorGood, power_button, chargerPresent, abnormalVoltage,
                               monitoring_adc_irq, charger_interface_irq};

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            syncA <= '0;
            syncB <= '0;
        end
        else
        begin
            syncA <= rawIn;
            syncB <= syncA;
        end
    end

    wire mainPresent  = syncB[9];
    wire backPresent  = syncB[8];
    wire mainAbove    = syncB[7];
    wire backOk       = syncB[6];
    wire regGood      = syncB[5];
    wire buttonLevel  = syncB[4];
    wire chargerLevel = syncB[3];
    wire abnormal     = syncB[2];
    wire adcIrq       = syncB[1];
    wire chgIrq       = syncB[0];

    // ****************************************************************
    // Slow clock enable
    // ****************************************************************
    logic slowTick;

    abbps_divider #(
        .DIV (ABBPS_SLOW_DIV)
    ) u_div (
        .clock (clock),
        .rst   (rst),
        .tick  (slowTick)
    );

    // ****************************************************************
    // Battery conditions
    // ****************************************************************
    wire batteryValid = (mainPresent & mainAbove) | (backPresent & backOk);
    wire batteryLost  = ~batteryValid | (~mainPresent & ~backPresent);

    // ****************************************************************
    // Edge detection of permanent functions
    // ****************************************************************
    logic [2:0] levelPrev;

    always_ff @(posedge clock)
    begin
        if (rst)
            levelPrev <= 3'h0;
        else
            levelPrev <= {abnormal, chargerLevel, buttonLevel};
    end

    wire buttonPress  = buttonLevel & ~levelPrev[0];
    wire chargerPlug  = chargerLevel & ~levelPrev[1];
    wire abnormalRise = abnormal & ~levelPrev[2];
    wire wakeRequest  = buttonPress | chargerPlug;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    abbps_state_t state;
    abbps_state_t next_state;
    logic [2:0]   wdogCount;
    logic [3:0]   offMask;
    logic         autoStart;
    logic         warnPulse;

    always_comb
    begin
        next_state = state;
        warnPulse  = 1'b0;
        case (state)
            ABBPS_OFF:
                if (wakeRequest | (autoStart & batteryValid))
                    next_state = ABBPS_REFON;
            ABBPS_REFON:
                next_state = ABBPS_BATCHK;
            ABBPS_BATCHK:
                next_state = (mainPresent & mainAbove) ? ABBPS_REGWAIT : ABBPS_SHUT;
            ABBPS_REGWAIT:
                if (batteryLost)
                    next_state = ABBPS_SHUT;
                else if (regGood)
                    next_state = ABBPS_RELRST;
            ABBPS_RELRST:
                next_state = ABBPS_SYSRST;
            ABBPS_SYSRST:
                next_state = ABBPS_ON;
            ABBPS_ON:
                if (batteryLost)
                begin
                    next_state = ABBPS_WARN;
                    warnPulse  = 1'b1;
                end
            ABBPS_WARN:
                next_state = ABBPS_WDOG;
            ABBPS_WDOG:
                if (slowTick && wdogCount == 3'(ABBPS_WDOG_PERIODS - 1))
                    next_state = ABBPS_SHUT;
            ABBPS_SHUT:
                next_state = ABBPS_OFF;
            default:
                next_state = ABBPS_OFF;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            state <= ABBPS_OFF;
        else
            state <= next_state;
    end

    always_ff @(posedge clock)
    begin
        if (rst || state != ABBPS_WDOG)
            wdogCount <= 3'h0;
        else if (slowTick)
            wdogCount <= wdogCount + 3'h1;
    end

    // First valid battery after reset starts one sequence by itself
    always_ff @(posedge clock)
    begin
        if (rst)
            autoStart <= 1'b1;
        else if (state != ABBPS_OFF)
            autoStart <= 1'b0;
    end

    // ****************************************************************
    // Power outputs
    // ****************************************************************
    wire inOnPhase = (state == ABBPS_ON) | (state == ABBPS_WARN) | (state == ABBPS_WDOG);
    wire regOn     = (state == ABBPS_REGWAIT) | (state == ABBPS_RELRST) | (state == ABBPS_SYSRST) | inOnPhase;
    wire [3:0] keepRegs = ~offMask;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            referenceEnable     <= 1'b0;
            core_regulator_en   <= 1'b0;
            analog_regulator_en <= 1'b0;
            memory_regulator_en <= 1'b0;
            ram_regulator_en    <= 1'b0;
            on_state_flag       <= 1'b0;
            analog_reset_n      <= 1'b0;
            system_reset_out_n  <= 1'b0;
            oscillatorEnable    <= 1'b0;
        end
        else
        begin
            referenceEnable     <= (state != ABBPS_OFF) & (next_state != ABBPS_OFF);
            core_regulator_en   <= (regOn & next_state != ABBPS_SHUT) | (core_regulator_en & keepRegs[0]);
            analog_regulator_en <= (regOn & next_state != ABBPS_SHUT) | (analog_regulator_en & keepRegs[1]);
            memory_regulator_en <= (regOn & next_state != ABBPS_SHUT) | (memory_regulator_en & keepRegs[2]);
            ram_regulator_en    <= (regOn & next_state != ABBPS_SHUT) | (ram_regulator_en & keepRegs[3]);
            on_state_flag       <= (next_state == ABBPS_RELRST) | (on_state_flag & ~(state == ABBPS_WDOG & next_state == ABBPS_SHUT));
            analog_reset_n      <= (state == ABBPS_RELRST) | (state == ABBPS_SYSRST) | inOnPhase & ~(state == ABBPS_WDOG & next_state == ABBPS_SHUT);
            system_reset_out_n  <= (state == ABBPS_SYSRST) | (state == ABBPS_ON) | (state == ABBPS_WARN) | (state == ABBPS_WDOG);
            oscillatorEnable    <= (state == ABBPS_ON) | (state == ABBPS_WARN) | (state == ABBPS_WDOG);
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            main_battery_low_flag <= 1'b0;
        else if (state == ABBPS_SHUT)
            main_battery_low_flag <= 1'b0;
        else if (mainPresent && !mainAbove)
            main_battery_low_flag <= 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            power_off_warning_irq <= 1'b0;
        else
            power_off_warning_irq <= warnPulse | (state == ABBPS_WARN) | (state == ABBPS_WDOG);
    end

    // ****************************************************************
    // Interrupt status, clear and enable
    // ****************************************************************
    logic [ABBPS_NUM_IRQ-1:0] irqStatus;
    logic [ABBPS_NUM_IRQ-1:0] irqEnable;
    logic [ABBPS_NUM_IRQ-1:0] irqClear;
    wire  [ABBPS_NUM_IRQ-1:0] irqEvent = {chargerPlug, chgIrq, adcIrq, abnormalRise, buttonPress, warnPulse};

    genvar gi;
    generate
        for (gi = 0; gi < ABBPS_NUM_IRQ; gi++)
        begin : g_irq
            always_ff @(posedge clock)
            begin
                if (rst)
                    irqStatus[gi] <= 1'b0;
                else if (irqEvent[gi])
                    irqStatus[gi] <= 1'b1;
                else if (irqClear[gi])
                    irqStatus[gi] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (rst)
            host_combined_irq <= 1'b0;
        else
            host_combined_irq <= |(irqStatus & irqEnable);
    end

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    logic       dataWrite;
    logic [7:0] dataAddr;
    wire        addrValid = hsel & hready & htrans[1];
    wire        wrCtrl    = dataWrite & (dataAddr == ABBPS_CTRL_OFS);
    wire        wrClr     = dataWrite & (dataAddr == ABBPS_IRQCLR_OFS);
    wire        wrEn      = dataWrite & (dataAddr == ABBPS_IRQEN_OFS);
    wire [31:0] readMux =
        (haddr[7:0] == ABBPS_CTRL_OFS)    ? {28'h0, offMask} :
        (haddr[7:0] == ABBPS_STATUS_OFS)  ? {18'h0, main_battery_low_flag, on_state_flag,
                                             regGood, batteryValid, state} :
        (haddr[7:0] == ABBPS_IRQSTAT_OFS) ? {26'h0, irqStatus} :
        (haddr[7:0] == ABBPS_IRQEN_OFS)   ? {26'h0, irqEnable} : 32'h0000_0000;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irqClear  = wrClr ? hwdata[ABBPS_NUM_IRQ-1:0] : '0;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            dataWrite <= 1'b0;
            dataAddr  <= 8'h00;
        end
        else
        begin
            dataWrite <= addrValid & hwrite;
            dataAddr  <= haddr[7:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            hrdata <= 32'h0000_0000;
        else if (addrValid && !hwrite)
            hrdata <= readMux;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            offMask   <= ABBPS_OFFMASK_RST;
            irqEnable <= ABBPS_IRQEN_RST;
        end
        else
        begin
            if (wrCtrl)
                offMask <= hwdata[3:0];
            if (wrEn)
                irqEnable <= hwdata[ABBPS_NUM_IRQ-1:0];
        end
    end
endmodule // abbps_sequencer

//--- rtl/abbps_pkg.sv
// Package with register map, field positions, timing and state encodings of the power sequencer
package abbps_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] ABBPS_CTRL_OFS    = 8'h00;
    localparam logic [7:0] ABBPS_STATUS_OFS  = 8'h04;
    localparam logic [7:0] ABBPS_IRQSTAT_OFS = 8'h08;
    localparam logic [7:0] ABBPS_IRQCLR_OFS  = 8'h0c;
    localparam logic [7:0] ABBPS_IRQEN_OFS   = 8'h10;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int          ABBPS_NUM_REG       = 4;
    localparam int          ABBPS_NUM_IRQ       = 6;
    localparam logic [3:0]  ABBPS_OFFMASK_RST   = 4'hf;
    localparam logic [5:0]  ABBPS_IRQEN_RST     = 6'h00;
    localparam int          ABBPS_IRQ_WARN      = 0;
    localparam int          ABBPS_IRQ_BUTTON    = 1;
    localparam int          ABBPS_IRQ_ABNORMAL  = 2;
    localparam int          ABBPS_IRQ_ADC       = 3;
    localparam int          ABBPS_IRQ_CHARGER   = 4;
    localparam int          ABBPS_IRQ_CHGDET    = 5;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          ABBPS_CLOCK_HZ      = 10_000_000;
    localparam int          ABBPS_SLOW_HZ       = 32_768;
    localparam int          ABBPS_SLOW_DIV      = ABBPS_CLOCK_HZ / ABBPS_SLOW_HZ;
    localparam int          ABBPS_WDOG_PERIODS  = 5;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [9:0] {
        ABBPS_OFF      = 10'h001,
        ABBPS_REFON    = 10'h002,
        ABBPS_BATCHK   = 10'h004,
        ABBPS_REGWAIT  = 10'h008,
        ABBPS_RELRST   = 10'h010,
        ABBPS_SYSRST   = 10'h020,
        ABBPS_ON       = 10'h040,
        ABBPS_WARN     = 10'h080,
        ABBPS_WDOG     = 10'h100,
        ABBPS_SHUT     = 10'h200
    } abbps_state_t;

endpackage

//--- rtl/abbps_divider.sv
// Divider giving a one-cycle enable per slow 32 kHz period
module abbps_divider #(
    parameter int DIV = abbps_pkg::ABBPS_SLOW_DIV
) (
    input  wire logic clock,
    input  wire logic rst,
    output logic      tick
);
    import abbps_pkg::*;

    if (DIV < 2 || DIV > 65536)
    begin : g_bad_div
        $error("abbps_divider: DIV must lie between 2 and 65536");
    end

    logic [15:0] count;
    wire         atEnd = (count == 16'(DIV - 1));

    always_ff @(posedge clock)
    begin
        if (rst)
            count <= 16'h0000;
        else
            count <= atEnd ? 16'h0000 : count + 16'h0001;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            tick <= 1'b0;
        else
            tick <= atEnd;
    end
endmodule // abbps_divider

//--- verification/abbps_props.sv
// Checker of power sequencing order, watchdog span and bus response
module abbps_props (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic mainBatteryPresent,
    input  wire logic mainBatteryAbove3v2,
    input  wire logic regulatorGood,
    input  wire logic hreadyout,
    input  wire logic hresp,
    input  wire logic referenceEnable,
    input  wire logic core_regulator_en,
    input  wire logic on_state_flag,
    input  wire logic analog_reset_n,
    input  wire logic system_reset_out_n,
    input  wire logic oscillatorEnable,
    input  wire logic power_off_warning_irq,
    input  wire logic host_combined_irq
);
    timeunit 1ns;
    timeprecision 1ns;

    // ********************************
    // Warning span counter
    // ********************************
    logic [11:0] warnCount;

    always_ff @(posedge clock)
    begin
        if (rst || !power_off_warning_irq)
            warnCount <= 12'h000;
        else if (warnCount != 12'hfff)
            warnCount <= warnCount + 12'h001;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // ********************************
    // Assertions
    // ********************************
    a_ref_first: assert property ($rose(core_regulator_en) |-> $past(referenceEnable))
        else $error("regulators on before reference");
    a_check_gates: assert property ($rose(core_regulator_en) |-> mainBatteryPresent && mainBatteryAbove3v2)
        else $error("regulators on without battery check");
    a_good_first: assert property ($rose(on_state_flag) |-> regulatorGood && core_regulator_en)
        else $error("on flag before regulators good");
    a_reset_order: assert property ($rose(system_reset_out_n) |-> $past(analog_reset_n) && on_state_flag)
        else $error("system reset released too early");
    a_osc_last: assert property ($rose(oscillatorEnable) |-> $past(system_reset_out_n))
        else $error("oscillator before system reset release");
    a_warn_first: assert property ($fell(on_state_flag) |-> $past(power_off_warning_irq))
        else $error("on flag cleared without warning");
    a_watchdog_span: assert property ($fell(on_state_flag) |-> warnCount >= 12'd1200 && warnCount <= 12'd1560)
        else $error("watchdog span wrong");
    a_analog_reset: assert property ($fell(on_state_flag) |-> ##[0:2] !analog_reset_n)
        else $error("analog reset not asserted after on flag");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus response not ready or not okay");

    c_switched_on: cover property ($rose(oscillatorEnable));
    c_shutdown: cover property ($fell(on_state_flag));
    c_host_irq: cover property ($rose(host_combined_irq));
endmodule // abbps_props

bind abbps_sequencer abbps_props u_abbps_props (
    .clock, .rst, .mainBatteryPresent, .mainBatteryAbove3v2, .regulatorGood, .hreadyout, .hresp,
    .referenceEnable, .core_regulator_en, .on_state_flag, .analog_reset_n, .system_reset_out_n,
    .oscillatorEnable, .power_off_warning_irq, .host_combined_irq
);

//--- verification/abbps_partner.sv
// Model of the regulator supervisor reporting regulators good after a settle time
module abbps_partner (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic regulatorsOn,
    input  wire logic slow,
    output logic      regulatorGood
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [5:0] settle;

    always_ff @(posedge clock)
    begin
        if (rst || !regulatorsOn)
        begin
            settle        <= 6'h00;
            regulatorGood <= 1'b0;
        end
        else if (settle == (slow ? 6'h28 : 6'h03))
            regulatorGood <= 1'b1;
        else
            settle <= settle + 6'h01;
    end
endmodule // abbps_partner

//--- verification/analog_baseband_power_sequencer_bench.sv
// Self-checking bench of the power sequencer
module analog_baseband_power_sequencer_bench import abbps_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        mainBatteryPresent = 1'b0;
    logic        backupBatteryPresent = 1'b0;
    logic        mainBatteryAbove3v2 = 1'b0;
    logic        backupBatteryOk = 1'b0;
    logic [4:0]  evt = 5'h00;
    logic        slow = 1'b0;
    logic        hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, regulatorGood, referenceEnable, core_regulator_en, analog_regulator_en;
    logic        memory_regulator_en, ram_regulator_en, on_state_flag, analog_reset_n, system_reset_out_n;
    logic        oscillatorEnable, main_battery_low_flag, power_off_warning_irq, host_combined_irq;
    int          n_errors = 0;
    int          tests_run = 0;
    int          i;
    int          k;

    always #50 clock = ~clock;

    abbps_sequencer u_abbps_sequencer (
        .clock, .rst, .mainBatteryPresent, .backupBatteryPresent, .mainBatteryAbove3v2, .backupBatteryOk,
        .regulatorGood, .power_button(evt[0]), .abnormalVoltage(evt[1]), .monitoring_adc_irq(evt[2]),
        .charger_interface_irq(evt[3]), .chargerPresent(evt[4]), .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .referenceEnable,
        .core_regulator_en, .analog_regulator_en, .memory_regulator_en, .ram_regulator_en, .on_state_flag,
        .analog_reset_n, .system_reset_out_n, .oscillatorEnable, .main_battery_low_flag,
        .power_off_warning_irq, .host_combined_irq
    );

    abbps_partner u_abbps_partner (
        .clock, .rst, .slow, .regulatorGood,
        .regulatorsOn(core_regulator_en & analog_regulator_en & memory_regulator_en & ram_regulator_en)
    );

    // ********************************
    // Shared tasks
    // ********************************
    task automatic chk(input logic c, input string m);
        tests_run++;
        if (c !== 1'b1)
        begin
            n_errors++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic close_out();
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset();
        chk((referenceEnable | system_reset_out_n | oscillatorEnable | on_state_flag) === 1'b0, "outputs");
        bus(1'b0, ABBPS_STATUS_OFS, 32'h0);
        chk(rd[9:0] === 10'h001, "not resting off");
        bus(1'b0, ABBPS_CTRL_OFS, 32'h0);
        chk(rd[3:0] === ABBPS_OFFMASK_RST, "mask reset value");
        bus(1'b0, ABBPS_IRQEN_OFS, 32'h0);
        chk(rd[5:0] === ABBPS_IRQEN_RST, "enable reset value");
        bus(1'b1, 8'h20, 32'hffffffff);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd === 32'h0, "unmapped read");
    endtask

    task automatic t_fail();
        mainBatteryPresent   <= 1'b1;
        backupBatteryPresent <= 1'b1;
        backupBatteryOk      <= 1'b1;
        bus(1'b1, ABBPS_IRQEN_OFS, 32'h20);
        evt[4] <= 1'b1;
        for (i = 0; i < 100; i++)
        begin
            @(negedge clock);
            chk((core_regulator_en | ram_regulator_en | oscillatorEnable | system_reset_out_n) === 1'b0, "on");
        end
        bus(1'b0, ABBPS_IRQSTAT_OFS, 32'h0);
        chk(rd[5] === 1'b1, "charger plug missed while off");
        chk(host_combined_irq === 1'b1, "host irq missing");
        evt[4] <= 1'b0;
        bus(1'b1, ABBPS_IRQCLR_OFS, 32'h3f);
        repeat (3) @(negedge clock);
        chk(host_combined_irq === 1'b0, "host irq not cleared");
    endtask

    task automatic t_power_on();
        @(posedge clock);
        slow                <= 1'b1;
        mainBatteryAbove3v2 <= 1'b1;
        evt[0]              <= 1'b1;
        for (i = 0; i < 400 && core_regulator_en !== 1'b1; i++) @(negedge clock);
        chk(referenceEnable === 1'b1, "reference off");
        chk((analog_regulator_en & memory_regulator_en & ram_regulator_en) === 1'b1, "regulators");
        chk((on_state_flag | system_reset_out_n) === 1'b0, "no wait for good");
        @(posedge clock);
        evt[0] <= 1'b0;
        for (i = 0; i < 400 && oscillatorEnable !== 1'b1; i++) @(negedge clock);
        chk((on_state_flag & analog_reset_n & system_reset_out_n) === 1'b1, "not switched on");
        bus(1'b0, ABBPS_STATUS_OFS, 32'h0);
        chk(rd[12] === 1'b1 && rd[9:0] === ABBPS_ON, "status on");
    endtask

    task automatic t_irq();
        bus(1'b1, ABBPS_IRQCLR_OFS, 32'h3f);
        bus(1'b1, ABBPS_IRQEN_OFS, 32'h3e);
        for (k = 0; k < 4; k++)
        begin
            @(posedge clock);
            evt[k] <= 1'b1;
            repeat (6) @(negedge clock);
            chk(host_combined_irq === 1'b1, "source not reaching host");
            bus(1'b0, ABBPS_IRQSTAT_OFS, 32'h0);
            chk(rd[5:0] === (6'h02 << k), "status bit");
            evt[k] <= 1'b0;
            repeat (2) @(posedge clock);
            bus(1'b1, ABBPS_IRQCLR_OFS, 32'h2 << k);
            repeat (3) @(negedge clock);
            chk(host_combined_irq === 1'b0, "clear failed");
        end
        bus(1'b1, ABBPS_IRQEN_OFS, 32'h0);
        evt[1] <= 1'b1;
        repeat (6) @(negedge clock);
        chk(host_combined_irq === 1'b0, "masked irq seen");
        bus(1'b0, ABBPS_IRQSTAT_OFS, 32'h0);
        chk(rd[2] === 1'b1, "abnormal status missing");
        evt[1] <= 1'b0;
        bus(1'b1, ABBPS_IRQCLR_OFS, 32'h3f);
    endtask

    task automatic t_power_off();
        bus(1'b1, ABBPS_CTRL_OFS, 32'h5);
        bus(1'b1, ABBPS_IRQEN_OFS, 32'h1);
        mainBatteryPresent   <= 1'b0;
        backupBatteryPresent <= 1'b0;
        backupBatteryOk      <= 1'b0;
        mainBatteryAbove3v2  <= 1'b0;
        for (i = 0; i < 20 && power_off_warning_irq !== 1'b1; i++) @(negedge clock);
        chk(on_state_flag === 1'b1 && power_off_warning_irq === 1'b1, "no warning first");
        @(negedge clock);
        chk(host_combined_irq === 1'b1, "warning not at host");
        for (i = 0; i < 2000 && on_state_flag !== 1'b0; i++) @(negedge clock);
        chk(i >= 1200 && i <= 1560, "watchdog span");
        repeat (4) @(negedge clock);
        chk((analog_reset_n | referenceEnable | main_battery_low_flag) === 1'b0, "shutdown");
        chk(core_regulator_en === 1'b0 && memory_regulator_en === 1'b0, "masked on");
        chk(analog_regulator_en === 1'b1 && ram_regulator_en === 1'b1, "unmasked off");
    endtask

    initial
    begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        t_reset();
        t_fail();
        t_power_on();
        t_irq();
        t_power_off();
        close_out();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        n_errors++;
        close_out();
    end
endmodule // analog_baseband_power_sequencer_bench
